// *** i2c_master_model.sv ***
// bus master model that drives scl and pulls sda for the decoder bench
`timescale 1ns/1ps
module i2c_master_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // quarter of the 48 ns bus clock; scl stands high between frames
    localparam time Q = 12;

    // idle bus with both lines released
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // start, or repeated start when scl is low
    task automatic start();
        if (!scl)
        begin
            sda_pull = 1'b0;
            #Q;
            scl = 1'b1;
            #(2*Q);
        end
        sda_pull = 1'b1;
        #(2*Q);
        scl = 1'b0;
        #Q;
    endtask : start

    // one bit: data moves only while scl low, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        sda_pull = ~b;
        #Q;
        scl = 1'b1;
        #Q;
        s = sda;
        #Q;
        scl = 1'b0;
        #Q;
    endtask : bit_io

    // byte out msb first; ack returns 0 when the slave acknowledged
    task automatic tx(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask : tx

    // byte in; ack or withhold ack on the ninth pulse
    task automatic rx(output logic [7:0] b, input logic give_ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(~give_ack, s);
    endtask : rx

    // stop condition, then the bus is left idle
    task automatic stop();
        sda_pull = 1'b1;
        #Q;
        scl = 1'b1;
        #(2*Q);
        sda_pull = 1'b0;
        #(2*Q);
    endtask : stop
endmodule : i2c_master_model

// *** lcd_cmd_decoder.sv ***
// serial-bus slave framing and command decoder for the lcd driver
`timescale 1ns/1ps
module lcd_cmd_decoder #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_pin,
    input wire logic sda_pin_in,
    output logic sda_pin_out,
    output logic sda_pin_oe_n,
    input wire logic address_strap_input,
    output lcd_cmd_pkg::cfg_t cfg,
    output lcd_cmd_pkg::disp_word_t wr_word,
    output logic wr_valid,
    input wire logic wr_ready,
    input wire logic [7:0] rd_data,
    output logic rd_take
);
    import lcd_cmd_pkg::*;

    // -------------------------------------------------------------
    // state and helpers
    // -------------------------------------------------------------
    typedef struct packed {
        phase_t phase;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic ack;
        logic drive;
        logic nacked;
        logic last_scl;
        logic last_sda;
        logic strap;
        logic [1:0] strap_wait;
        cfg_t cfg;
    } state_t;

    state_t s;
    state_t next_s;
    logic [2:0] pins_q;
    logic scl;
    logic sda;
    logic strap_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic push;
    logic push_ready;
    disp_word_t push_word;
    logic addr_ok;
    logic data_ok;

    // classify a command byte by its opcode bits
    function automatic cmd_t cmd_kind(input logic [7:0] b);
        cmd_t k;
        if (!b[6])
            k = CMD_XADDR;
        else if (!b[5])
            k = CMD_MODE;
        else if (b[6:2] == 5'h1F)
            k = CMD_BANK;
        else if (!b[4])
            k = CMD_DEVSEL;
        else
            k = CMD_RAM;
        return k;
    endfunction : cmd_kind

    // step column, carrying into subaddress at the row end
    function automatic cfg_t advance(input cfg_t c);
        cfg_t r;
        r = c;
        if (c.column == LAST_COLUMN)
        begin
            r.column = COLUMN_RST;
            r.subaddr = c.subaddr + 4'h1;
        end
        else
            r.column = c.column + 6'h01;
        return r;
    endfunction : advance

    // -------------------------------------------------------------
    // pin sampling
    // -------------------------------------------------------------
    lcd_sync #(
        .W(3)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({address_strap_input, scl_pin, sda_pin_in}),
        .q(pins_q)
    );

    assign strap_q = pins_q[2];
    assign scl = pins_q[1];
    assign sda = pins_q[0];

    // edges come from the synchronised copy, never the first stage
    assign scl_rise = scl && !s.last_scl;
    assign scl_fall = !scl && s.last_scl;
    assign start_seen = scl && s.last_scl && s.last_sda && !sda;
    assign stop_seen = scl && s.last_scl && !s.last_sda && sda;

    // -------------------------------------------------------------
    // acknowledge decisions
    // -------------------------------------------------------------
    // reads answered only in mixed mode; row-only stays a receiver
    assign addr_ok = (s.shreg[7:1] == {SLAVE_ADDR_HI, s.strap})
        && (!s.shreg[RW_BIT] || s.cfg.mixed_mode);

    // a full fifo withholds the acknowledge, so no byte is lost silently
    assign data_ok = s.cfg.mixed_mode
        && (s.cfg.subaddr == OWN_SUBADDR) && push_ready;

    assign push_word.bank = s.cfg.bank_pick;
    assign push_word.column = s.cfg.column;
    assign push_word.data = s.shreg;

    // -------------------------------------------------------------
    // framing and decode
    // -------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        push = 1'b0;
        rd_take = 1'b0;
        next_s.last_scl = scl;
        next_s.last_sda = sda;
        // strap settles once the sync stages hold the pin, not reset ones
        if (s.strap_wait != 2'h3)
        begin
            next_s.strap = strap_q;
            next_s.strap_wait = s.strap_wait + 2'h1;
        end
        if (start_seen)
        begin
            next_s.phase = PH_ADDR;
            next_s.bits = 4'h0;
            next_s.ack = 1'b0;
            next_s.drive = 1'b0;
            next_s.nacked = 1'b0;
        end
        else if (stop_seen)
        begin
            next_s.phase = PH_IDLE;
            next_s.bits = 4'h0;
            next_s.ack = 1'b0;
            next_s.drive = 1'b0;
        end
        else if (s.phase != PH_IDLE)
        begin
            // sample on rising scl only; changes while high are conditions
            if (scl_rise)
            begin
                if (s.bits < BYTE_BITS)
                begin
                    if (s.phase != PH_READ)
                        next_s.shreg = {s.shreg[6:0], sda};
                    next_s.bits = s.bits + 4'h1;
                end
                else if (s.phase == PH_READ && sda)
                    next_s.nacked = 1'b1;
            end
            if (scl_fall)
            begin
                if (s.bits == BYTE_BITS && !s.ack)
                begin
                    // eighth bit done: open the acknowledge slot
                    next_s.ack = 1'b1;
                    case (s.phase)
                        PH_ADDR:
                            next_s.drive = addr_ok;
                        PH_CMD:
                            next_s.drive = 1'b1;
                        PH_DATA:
                        begin
                            next_s.drive = data_ok;
                            push = data_ok;
                        end
                        default:
                            next_s.drive = 1'b0; // master acknowledges
                    endcase
                end
                else if (s.ack)
                begin
                    // ninth clock over: release and act on the byte
                    next_s.ack = 1'b0;
                    next_s.bits = 4'h0;
                    next_s.drive = 1'b0;
                    case (s.phase)
                        PH_ADDR:
                        begin
                            if (!s.drive)
                                next_s.phase = PH_IDLE;
                            else if (s.shreg[RW_BIT])
                            begin
                                next_s.phase = PH_READ;
                                next_s.shreg = rd_data;
                                next_s.drive = !rd_data[7];
                                rd_take = 1'b1;
                            end
                            else
                                next_s.phase = PH_CMD;
                        end
                        PH_CMD:
                        begin
                            case (cmd_kind(s.shreg))
                                CMD_MODE:
                                begin
                                    next_s.cfg.mixed_mode =
                                        s.shreg[MODE_TYPE_BIT];
                                    next_s.cfg.display_status =
                                        s.shreg[MODE_STATUS_LSB +: 2];
                                    next_s.cfg.mux_rate =
                                        s.shreg[MODE_MUX_LSB +: 2];
                                end
                                CMD_BANK:
                                    next_s.cfg.top_bank =
                                        s.shreg[BANK_LSB +: 2];
                                CMD_DEVSEL:
                                    next_s.cfg.subaddr =
                                        s.shreg[DEVSEL_LSB +: 4];
                                CMD_RAM:
                                begin
                                    // low nibble 12 up decodes as bank above
                                    next_s.cfg.access_order =
                                        s.shreg[RAM_ORDER_LSB +: 2];
                                    next_s.cfg.bank_pick =
                                        s.shreg[RAM_BANK_LSB +: 2];
                                end
                                default:
                                    next_s.cfg.column =
                                        s.shreg[XADDR_LSB +: 6];
                            endcase
                            if (!s.shreg[CONT_BIT])
                                next_s.phase = PH_DATA;
                            else
                                next_s.phase = PH_CMD;
                        end
                        PH_DATA:
                            next_s.cfg = advance(s.cfg);
                        default:
                        begin
                            next_s.cfg = advance(s.cfg);
                            if (s.nacked)
                                next_s.phase = PH_IDLE;
                            else
                            begin
                                next_s.shreg = rd_data;
                                next_s.drive = !rd_data[7];
                                rd_take = 1'b1;
                            end
                        end
                    endcase
                end
                else if (s.phase == PH_READ)
                begin
                    // next bit goes out while scl is low
                    next_s.shreg = {s.shreg[6:0], 1'b1};
                    next_s.drive = !s.shreg[6];
                end
            end
        end
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    // settings hold until rewritten or reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.phase <= PH_IDLE;
            s.last_scl <= 1'b1;
            s.last_sda <= 1'b1;
            s.cfg.mux_rate <= MUX_RST;
            s.cfg.display_status <= STATUS_RST;
            s.cfg.mixed_mode <= MIXED_RST;
            s.cfg.top_bank <= TOP_BANK_RST;
            s.cfg.subaddr <= SUBADDR_RST;
            s.cfg.access_order <= ORDER_RST;
            s.cfg.bank_pick <= BANK_PICK_RST;
            s.cfg.column <= COLUMN_RST;
        end
        else
            s <= next_s;
    end

    // -------------------------------------------------------------
    // data path and outputs
    // -------------------------------------------------------------
    lcd_fifo #(
        .W($bits(disp_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_word)
    );

    // open drain: only ever pulls low, enable low while pulling
    assign sda_pin_out = 1'b0;
    assign sda_pin_oe_n = !s.drive;
    assign cfg = s.cfg;
endmodule : lcd_cmd_decoder

// *** lcd_cmd_decoder_chk.sv ***
// concurrent checks on the ports of the lcd command decoder
`timescale 1ns/1ps
module lcd_cmd_decoder_chk
    import lcd_cmd_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_pin,
    input wire logic sda_pin_in,
    input wire logic sda_pin_out,
    input wire logic sda_pin_oe_n,
    input wire logic address_strap_input,
    input lcd_cmd_pkg::cfg_t cfg,
    input lcd_cmd_pkg::disp_word_t wr_word,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [7:0] rd_data,
    input wire logic rd_take
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ---------------------------------------------------------------
    // helper logic
    // ---------------------------------------------------------------
    // run length of sda pull-down; a stuck pull would hang the bus
    logic [7:0] low_cnt;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            low_cnt <= 8'h00;
        else if (sda_pin_oe_n)
            low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF)
            low_cnt <= low_cnt + 8'h01;
    end

    sequence scl_rise;
        !scl_pin ##1 scl_pin;
    endsequence
    sequence held_low;
        !sda_pin_oe_n [*4];
    endsequence

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    AST_OPEN_DRAIN: assert property (sda_pin_out == 1'b0)
        else $error("sda drive value is not zero");
    AST_SDA_STEADY: assert property (
        scl_pin && $past(scl_pin) |-> $stable(sda_pin_oe_n))
        else $error("device moved sda while scl high");
    AST_ACK_HELD: assert property (
        scl_rise ##0 !sda_pin_oe_n |-> held_low)
        else $error("sda pull dropped inside scl high phase");
    AST_CFG_STEADY: assert property (
        !$stable(cfg) |-> !scl_pin)
        else $error("settings changed while scl high");
    AST_RESET_STATE: assert property (
        $rose(nrst) |-> cfg == '0 && sda_pin_oe_n && !wr_valid && !rd_take)
        else $error("outputs not at reset values");
    AST_FIFO_HOLD: assert property (
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
        else $error("fifo head dropped without ready");
    AST_PUSH_FIELDS: assert property (
        $rose(wr_valid) |-> cfg.mixed_mode && cfg.subaddr == OWN_SUBADDR
        && wr_word.column == cfg.column && wr_word.bank == cfg.bank_pick)
        else $error("stored word fields or gating wrong");
    AST_READ_PULSE: assert property (
        rd_take |-> cfg.mixed_mode ##1 !rd_take)
        else $error("read fetch outside mixed mode or too long");
    AST_PULL_BOUND: assert property (low_cnt < 8'd110)
        else $error("sda held low too long");
endmodule : lcd_cmd_decoder_chk

// *** lcd_cmd_pkg.sv ***
// constants, types and settings layout for the lcd command decoder
package lcd_cmd_pkg;

    // -------------------------------------------------------------
    // bus framing
    // -------------------------------------------------------------
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h1E;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int CONT_BIT = 7;
    localparam int RW_BIT = 0;

    // -------------------------------------------------------------
    // command field positions
    // -------------------------------------------------------------
    localparam int MODE_TYPE_BIT = 4;
    localparam int MODE_STATUS_LSB = 2;
    localparam int MODE_MUX_LSB = 0;
    localparam int RAM_ORDER_LSB = 2;
    localparam int RAM_BANK_LSB = 0;
    localparam int BANK_LSB = 0;
    localparam int DEVSEL_LSB = 0;
    localparam int XADDR_LSB = 0;

    // -------------------------------------------------------------
    // address space and reset values
    // -------------------------------------------------------------
    localparam logic [5:0] LAST_COLUMN = 6'h27;
    localparam logic [3:0] OWN_SUBADDR = 4'h0;
    localparam logic [1:0] MUX_RST = 2'h0;
    localparam logic [1:0] STATUS_RST = 2'h0;
    localparam logic MIXED_RST = 1'b0;
    localparam logic [1:0] TOP_BANK_RST = 2'h0;
    localparam logic [3:0] SUBADDR_RST = 4'h0;
    localparam logic [1:0] ORDER_RST = 2'h0;
    localparam logic [1:0] BANK_PICK_RST = 2'h0;
    localparam logic [5:0] COLUMN_RST = 6'h00;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ADDR = 3'b001,
        PH_CMD = 3'b011,
        PH_DATA = 3'b010,
        PH_READ = 3'b110
    } phase_t;

    typedef enum logic [2:0] {
        CMD_XADDR = 3'h0,
        CMD_MODE = 3'h1,
        CMD_DEVSEL = 3'h2,
        CMD_RAM = 3'h3,
        CMD_BANK = 3'h4
    } cmd_t;

    typedef struct packed {
        logic [1:0] mux_rate;
        logic [1:0] display_status;
        logic mixed_mode;
        logic [1:0] top_bank;
        logic [3:0] subaddr;
        logic [1:0] access_order;
        logic [1:0] bank_pick;
        logic [5:0] column;
    } cfg_t;

    typedef struct packed {
        logic [1:0] bank;
        logic [5:0] column;
        logic [7:0] data;
    } disp_word_t;

endpackage : lcd_cmd_pkg

// *** lcd_fifo.sv ***
// display data fifo with valid/ready on both sides
`timescale 1ns/1ps
module lcd_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
    } fifo_t;

    fifo_t s;
    fifo_t next_s;
    logic do_wr;
    logic do_rd;

    assign in_ready = (s.count != (AW+1)'(DEPTH));
    assign out_valid = (s.count != '0);
    assign out_data = s.mem[s.rp];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // pointers wrap at depth; depth is taken as a power of two
    always_comb
    begin
        next_s = s;
        if (do_wr)
        begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + AW'(1);
        end
        if (do_rd)
            next_s.rp = s.rp + AW'(1);
        if (do_wr && !do_rd)
            next_s.count = s.count + (AW+1)'(1);
        else if (do_rd && !do_wr)
            next_s.count = s.count - (AW+1)'(1);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= next_s;
    end
endmodule : lcd_fifo

// *** lcd_sync.sv ***
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module lcd_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t s;
    sync_t next_s;

    // stage one feeds stage two only
    always_comb
    begin
        next_s.s1 = d;
        next_s.s2 = s.s1;
    end

    // idle bus lines are high, so reset to ones
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s <= '1;
        else
            s <= next_s;
    end

    assign q = s.s2;
endmodule : lcd_sync

// *** testbench.sv ***
// self-checking bench for the lcd command decoder
`timescale 1ns/1ps
module testbench;
    import lcd_cmd_pkg::*;

    typedef struct packed {
        logic [7:0] cmd;
        logic [20:0] exp;
    } row_t;

    logic clk, nrst, scl, sda_pull, sda, sda_pin_out, sda_pin_oe_n;
    logic strap, wr_valid, wr_ready, rd_take;
    logic [7:0] rd_data, got;
    logic [3:0] rd_cnt;
    cfg_t cfg;
    disp_word_t wr_word;
    int fail_count = 0;
    int checked = 0;
    // cumulative settings after each single-command write
    row_t rows [15] = '{'{8'h41, 21'h080000}, '{8'h46, 21'h120000},
        '{8'h5B, 21'h1D0000}, '{8'h5C, 21'h070000}, '{8'h7D, 21'h074000},
        '{8'h7E, 21'h078000}, '{8'h7F, 21'h07C000}, '{8'h7C, 21'h070000},
        '{8'h6F, 21'h073C00}, '{8'h60, 21'h070000}, '{8'h76, 21'h070180},
        '{8'h79, 21'h070240}, '{8'h73, 21'h0700C0}, '{8'h27, 21'h0700E7},
        '{8'h00, 21'h0700C0}};

    // open-drain wire with pull-up: either party may pull it low
    assign sda = ~sda_pull & (sda_pin_oe_n | sda_pin_out);
    // read source steps once per fetch so each byte differs
    assign rd_data = {rd_cnt, ~rd_cnt};
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rd_cnt <= 4'h0;
        else if (rd_take)
            rd_cnt <= rd_cnt + 4'h1;
    end

    lcd_cmd_decoder #(.FIFO_DEPTH(16)) lcd_cmd_decoder_i (.clk(clk),
        .nrst(nrst), .scl_pin(scl), .sda_pin_in(sda),
        .sda_pin_out(sda_pin_out), .sda_pin_oe_n(sda_pin_oe_n),
        .address_strap_input(strap), .cfg(cfg), .wr_word(wr_word),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_take(rd_take));
    i2c_master_model i2c_master_model_i (.scl(scl), .sda_pull(sda_pull),
        .sda(sda));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] got_v, input logic [31:0] exp);
        checked++;
        if (got_v !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got_v,
                exp);
        end
    endtask : check

    task automatic chk_cfg(input logic [20:0] e);
        check({11'h0, cfg}, {11'h0, e});
    endtask : chk_cfg

    // send a byte and compare the acknowledge (1 means refused)
    task automatic send(input logic [7:0] b, input logic nack);
        logic a;
        i2c_master_model_i.tx(b, a);
        check({31'h0, a}, {31'h0, nack});
    endtask : send

    // take one fifo word; the sink stalls until the word is checked
    task automatic pop(input logic [15:0] exp);
        int n = 0;
        while (wr_valid !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check({16'h0, wr_word}, {16'h0, exp});
        wr_ready = 1'b1;
        @(posedge clk);
        #1;
        wr_ready = 1'b0;
        // one idle edge so back-to-back pops never retoggle ready
        @(posedge clk);
        #1;
    endtask : pop

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // ---------------------------------------------------------------
    // clock, watchdog and tests
    // ---------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // about 30 us of bus traffic expected; far beyond that is a hang
    initial
    begin
        #200000;
        fail_count++;
        complete_run();
    end

    initial
    begin
        nrst = 1'b0;
        wr_ready = 1'b0;
        strap = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        foreach (rows[r])
        begin
            i2c_master_model_i.start();
            send(8'h78, 1'b0);
            send(rows[r].cmd, 1'b0);
            i2c_master_model_i.stop();
            chk_cfg(rows[r].exp);
        end
        $display("test command table done");
        i2c_master_model_i.start();
        send(8'h78, 1'b0);
        send(8'hE0, 1'b0);
        send(8'hA6, 1'b0);
        send(8'h71, 1'b0);
        send(8'hA5, 1'b0);
        send(8'h3C, 1'b0);
        repeat (4) @(posedge clk);
        #1;
        check({28'h0, cfg.subaddr}, 32'h1);
        send(8'h11, 1'b1);
        i2c_master_model_i.stop();
        check({26'h0, cfg.column}, 32'h1);
        pop({2'h1, 6'h26, 8'hA5});
        pop({2'h1, 6'h27, 8'h3C});
        check({31'h0, wr_valid}, 32'h0);
        $display("test chained commands and data done");
        i2c_master_model_i.start();
        send(8'h78, 1'b0);
        send(8'hE0, 1'b0);
        send(8'h00, 1'b0);
        for (int i = 0; i < 16; i++)
            send(8'(i), 1'b0);
        send(8'hFF, 1'b1);
        i2c_master_model_i.stop();
        for (int i = 0; i < 16; i++)
            pop({2'h1, 6'(i), 8'(i)});
        check({31'h0, wr_valid}, 32'h0);
        $display("test fifo fill and drain done");
        i2c_master_model_i.start();
        send(8'h79, 1'b0);
        i2c_master_model_i.rx(got, 1'b1);
        check({24'h0, got}, 32'h0F);
        i2c_master_model_i.rx(got, 1'b0);
        check({24'h0, got}, 32'h1E);
        i2c_master_model_i.stop();
        check({31'h0, sda_pin_oe_n}, 32'h1);
        check({26'h0, cfg.column}, 32'h13);
        $display("test read done");
        nrst = 1'b0;
        strap = 1'b1;
        #1;
        chk_cfg(21'h0);
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        i2c_master_model_i.start();
        send(8'h78, 1'b1);
        i2c_master_model_i.stop();
        i2c_master_model_i.start();
        send(8'h7B, 1'b1);
        i2c_master_model_i.stop();
        i2c_master_model_i.start();
        send(8'h7A, 1'b0);
        send(8'h00, 1'b0);
        send(8'h33, 1'b1);
        i2c_master_model_i.start();
        send(8'h7A, 1'b0);
        send(8'h50, 1'b0);
        i2c_master_model_i.stop();
        check({31'h0, cfg.mixed_mode}, 32'h1);
        $display("test reset and addressing done");
        complete_run();
    end
endmodule : testbench

bind lcd_cmd_decoder lcd_cmd_decoder_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk_i (
    .clk(clk), .nrst(nrst), .scl_pin(scl_pin), .sda_pin_in(sda_pin_in),
    .sda_pin_out(sda_pin_out), .sda_pin_oe_n(sda_pin_oe_n),
    .address_strap_input(address_strap_input), .cfg(cfg),
    .wr_word(wr_word), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_take(rd_take));
